// file: spi_master_model.sv
// Behavioural SPI master facing the status readback block.
// Assumes the device samples on sclk rise and shifts on sclk fall.
`timescale 1ns/1ps
module spi_master_model (
  input wire logic clock_i,
  input wire logic miso_i,
  input wire logic miso_oe_i,
  output logic cs_n_o,
  output logic sclk_o,
  output logic mosi_o
);
  initial begin
    cs_n_o = 1'b1;
    sclk_o = 1'b0;
    mosi_o = 1'b0;
  end
  // Half period of 5 clocks keeps clear of the sync delay
  task automatic frame(input logic [7:0] cmd, input int nbits, output logic [7:0] rsp);
    rsp = 8'h00;
    @(negedge clock_i);
    cs_n_o = 1'b0;
    repeat (6) @(negedge clock_i);
    for (int i = 0; i < nbits; i++) begin
      mosi_o = cmd[7-i];
      repeat (5) @(negedge clock_i);
      sclk_o = 1'b1;
      rsp = {rsp[6:0], miso_oe_i ? miso_i : 1'bx};
      repeat (5) @(negedge clock_i);
      sclk_o = 1'b0;
    end
    repeat (5) @(negedge clock_i);
    cs_n_o = 1'b1;
    mosi_o = ~mosi_o;
    repeat (8) @(negedge clock_i);
  endtask
endmodule

// file: spi_status_readback_mux.sv
// SPI slave side of the status return: captures, shifts and updates selection.
// Assumes SPI pins, fault conditions and input pins arrive asynchronously.
`timescale 1ns/1ps
`include "status_readback_map.svh"
module spi_status_readback_mux (
  input wire logic clock_i,
  input wire logic rst_n_i,
  input wire logic clk_en_i,
  input wire logic spi_cs_n_i,
  input wire logic spi_sclk_i,
  input wire logic spi_mosi_i,
  input wire logic overtemp_cond_i,
  input wire logic overcurrent_high_cond_i,
  input wire logic overcurrent_low_cond_i,
  input wire logic open_load_cond_i,
  input wire logic undervoltage_cond_i,
  input wire logic overvoltage_cond_i,
  input wire logic undervoltage_latch_en_i,
  input wire logic current_sense_disable_i,
  input wire logic [3:0] oc_threshold_i,
  input wire logic [3:0] oc_timing_i,
  input wire logic [3:0] direct_input_control_reg_i,
  input wire logic [3:0] switching_delay_reg_i,
  input wire logic [1:0] watchdog_timeout_reg_i,
  input wire logic watchdog_expired_i,
  input wire logic [1:0] voltage_protect_reg_i,
  input wire logic direct_in_pin_i,
  input wire logic failsafe_input_pin_i,
  input wire logic wake_pin_i,
  output logic spi_miso_o,
  output logic spi_miso_oe_o,
  output logic failsafe_status_pin_o,
  output logic output_on_o,
  output logic word_valid_o,
  output logic [7:0] last_word_o
);
  import status_readback_pkg::*;

  localparam int SYNC_W = 12;
  logic [SYNC_W-1:0] sync1_reg;
  logic [SYNC_W-1:0] sync2_reg;
  logic cs_n_s;
  logic sclk_s;
  logic mosi_s;
  logic [5:0] cond_s;
  logic [2:0] pins_s;
  logic sclk_d_reg;
  logic cs_d_reg;
  link_state_e state_reg;
  status_word_t shift_out_reg;
  status_word_t shift_in_reg;
  status_word_t first_word_reg;
  logic [`BIT_CNT_W-1:0] bit_cnt_reg;
  logic any_bit_reg;
  logic first_done_reg;
  logic [2:0] select_code_reg;
  logic extra_addr_reg;
  logic watchdog_toggle_echo_reg;
  logic och_reg;
  logic ocl_reg;
  logic uv_reg;
  logic summary_reg;
  logic prev_dir_in_reg;
  low_bits_t low_bits;
  logic [6:0] fault_word;
  logic sclk_rise;
  logic sclk_fall;
  logic cs_fall;
  logic cs_rise;
  logic valid_end;
  logic any_fault;
  logic uv_now;

  // Two-stage synchronisers for every pin
  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      // Select bit resets to its idle level so that no false frame start follows reset
      sync1_reg <= {1'b1, {(SYNC_W-1){1'b0}}};
      sync2_reg <= {1'b1, {(SYNC_W-1){1'b0}}};
    end else if (clk_en_i) begin
      sync1_reg <= {spi_cs_n_i, spi_sclk_i, spi_mosi_i, overtemp_cond_i,
                    overcurrent_high_cond_i, overcurrent_low_cond_i, open_load_cond_i,
                    undervoltage_cond_i, overvoltage_cond_i, direct_in_pin_i,
                    failsafe_input_pin_i, wake_pin_i};
      sync2_reg <= sync1_reg;
    end
  end
  assign cs_n_s = sync2_reg[11];
  assign sclk_s = sync2_reg[10];
  assign mosi_s = sync2_reg[9];
  assign cond_s = sync2_reg[8:3];
  assign pins_s = sync2_reg[2:0];

  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      sclk_d_reg <= 1'b0;
      cs_d_reg <= 1'b1;
    end else if (clk_en_i) begin
      sclk_d_reg <= sclk_s;
      cs_d_reg <= cs_n_s;
    end
  end
  assign sclk_rise = sclk_s && !sclk_d_reg && !cs_n_s;
  assign sclk_fall = !sclk_s && sclk_d_reg && !cs_n_s;
  assign cs_fall = !cs_n_s && cs_d_reg;
  assign cs_rise = cs_n_s && !cs_d_reg;
  // Whole bytes only; an empty frame is not a command
  assign valid_end = cs_rise && (bit_cnt_reg == '0) && any_bit_reg;

  // Fault flags: latched ones hold, others follow the condition
  assign uv_now = cond_s[1];
  assign fault_word = {cond_s[5], och_reg, ocl_reg, cond_s[2],
                       undervoltage_latch_en_i ? uv_reg : uv_now,
                       cond_s[0], summary_reg};
  assign any_fault = |cond_s;

  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      och_reg <= 1'b0;
      ocl_reg <= 1'b0;
      uv_reg <= 1'b0;
    end else if (clk_en_i) begin
      // Over-current flags clear only on a valid output-on command; the UV flag clears at frame start when unlatched or with the fault code selected
      if (cond_s[4]) begin
        och_reg <= 1'b1;
      end else if (valid_end && output_on_cmd(shift_in_reg)) begin
        och_reg <= 1'b0;
      end
      if (cond_s[3]) begin
        ocl_reg <= 1'b1;
      end else if (valid_end && output_on_cmd(shift_in_reg)) begin
        ocl_reg <= 1'b0;
      end
      if (uv_now) begin
        uv_reg <= 1'b1;
      end else if (cs_fall && !undervoltage_latch_en_i) begin
        uv_reg <= 1'b0;
      end else if (cs_fall && select_code_reg == `SEL_FAULT) begin
        uv_reg <= 1'b0;
      end
    end
  end

  // Summary bit: set by any fault, cleared when read; set wins
  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      summary_reg <= 1'b0;
    end else if (clk_en_i) begin
      if (any_fault) begin
        summary_reg <= 1'b1;
      end else if (cs_fall && select_code_reg == `SEL_FAULT) begin
        summary_reg <= 1'b0;
      end
    end
  end

  // Fail-safe status pin: held until a switch-on arrives; set wins
  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      failsafe_status_pin_o <= 1'b0;
      prev_dir_in_reg <= 1'b0;
    end else if (clk_en_i) begin
      prev_dir_in_reg <= pins_s[2];
      if (any_fault) begin
        failsafe_status_pin_o <= 1'b1;
      end else if ((pins_s[2] && !prev_dir_in_reg) ||
                   (valid_end && output_on_cmd(shift_in_reg))) begin
        failsafe_status_pin_o <= 1'b0;
      end
    end
  end

  function automatic logic output_on_cmd(input status_word_t w);
    output_on_cmd = (w[`CMD_ADDR_MSB:`CMD_ADDR_LSB] == `ADDR_OUTCTL_LOW) && w[`CMD_ON_BIT];
  endfunction

  function automatic logic is_select_cmd(input status_word_t w);
    // Bit 3 is the extra address bit, so it must not take part in the decode
    is_select_cmd = (w[`CMD_ADDR_MSB:`CMD_ADDR_LSB] == `ADDR_STATUS_SELECT);
  endfunction

  // Framing state machine and shift registers
  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state_reg <= LINK_IDLE;
      shift_out_reg <= 8'h00;
      shift_in_reg <= 8'h00;
      bit_cnt_reg <= '0;
      any_bit_reg <= 1'b0;
      first_word_reg <= 8'h00;
      first_done_reg <= 1'b0;
      spi_miso_o <= 1'b0;
      spi_miso_oe_o <= 1'b0;
    end else if (clk_en_i) begin
      unique case (state_reg)
        LINK_IDLE: begin
          if (cs_fall) begin
            shift_out_reg <= {watchdog_toggle_echo_reg, low_bits};
            bit_cnt_reg <= '0;
            any_bit_reg <= 1'b0;
            first_done_reg <= 1'b0;
            spi_miso_o <= watchdog_toggle_echo_reg;
            spi_miso_oe_o <= 1'b1;
            state_reg <= LINK_SHIFT;
          end
        end
        LINK_SHIFT: begin
          if (cs_rise) begin
            spi_miso_oe_o <= 1'b0;
            state_reg <= LINK_CLOSE;
          end else if (sclk_rise) begin
            shift_in_reg <= {shift_in_reg[6:0], mosi_s};
            bit_cnt_reg <= bit_cnt_reg + 1'b1;
            any_bit_reg <= 1'b1;
            if (bit_cnt_reg == 3'h7) begin
              first_done_reg <= 1'b1;
              if (!first_done_reg) begin
                first_word_reg <= {shift_in_reg[6:0], mosi_s};
              end
            end
          end else if (sclk_fall) begin
            // After the first byte the input bits come out again
            shift_out_reg <= {shift_out_reg[6:0], 1'b0};
            spi_miso_o <= first_done_reg ? shift_in_reg[7] : shift_out_reg[6];
          end
        end
        LINK_CLOSE: begin
          spi_miso_o <= 1'b0;
          state_reg <= LINK_IDLE;
        end
        default: state_reg <= LINK_IDLE;
      endcase
    end
  end

  // Register updates from a valid frame: last byte is the command
  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      select_code_reg <= `SEL_NULL;
      extra_addr_reg <= 1'b0;
      watchdog_toggle_echo_reg <= 1'b0;
      output_on_o <= 1'b0;
      word_valid_o <= 1'b0;
      last_word_o <= 8'h00;
    end else if (clk_en_i) begin
      word_valid_o <= valid_end;
      if (valid_end) begin
        last_word_o <= shift_in_reg;
        watchdog_toggle_echo_reg <= shift_in_reg[`CMD_WD_BIT];
        if (is_select_cmd(shift_in_reg)) begin
          select_code_reg <= shift_in_reg[2:0];
          extra_addr_reg <= shift_in_reg[`CMD_EXTRA_BIT];
        end
        if (shift_in_reg[`CMD_ADDR_MSB:`CMD_ADDR_LSB] == `ADDR_OUTCTL_LOW) begin
          output_on_o <= shift_in_reg[`CMD_ON_BIT];
        end
      end
    end
  end

  status_word_mux u_mux (
    .select_code_i(select_code_reg),
    .extra_addr_i(extra_addr_reg),
    .fault_word_i(fault_word),
    .current_sense_disable_i(current_sense_disable_i),
    .output_on_i(output_on_o),
    .oc_threshold_i(oc_threshold_i),
    .oc_timing_i(oc_timing_i),
    .direct_input_control_reg_i(direct_input_control_reg_i),
    .switching_delay_reg_i(switching_delay_reg_i),
    .watchdog_timeout_reg_i(watchdog_timeout_reg_i),
    .watchdog_expired_i(watchdog_expired_i),
    .input_pin_levels_i(pins_s),
    .voltage_protect_reg_i(voltage_protect_reg_i),
    .low_bits_o(low_bits)
  );
endmodule

// file: spi_status_readback_mux_assertions.sv
// Port checker for the SPI status readback block.
// Assumes clk_en_i stays high, so cycle counts are real time.
`timescale 1ns/1ps
module spi_status_readback_mux_assertions (
  input wire logic clock_i,
  input wire logic rst_n_i,
  input wire logic spi_cs_n_i,
  input wire logic overtemp_cond_i,
  input wire logic direct_in_pin_i,
  input wire logic spi_miso_o,
  input wire logic spi_miso_oe_o,
  input wire logic failsafe_status_pin_o,
  input wire logic output_on_o,
  input wire logic word_valid_o,
  input wire logic [7:0] last_word_o
);
  default clocking @(posedge clock_i); endclocking
  default disable iff (!rst_n_i);
  // Five samples clear the two-clock pin sync
  sequence s_cs_idle; spi_cs_n_i [*5]; endsequence
  sequence s_cs_busy; !spi_cs_n_i [*5]; endsequence
  a_oe_released: assert property (s_cs_idle |-> !spi_miso_oe_o)
    else $error("miso enable high while deselected");
  a_oe_driving: assert property (s_cs_busy |-> spi_miso_oe_o)
    else $error("miso enable low while selected");
  a_echo_first: assert property ($rose(spi_miso_oe_o) |-> spi_miso_o == last_word_o[7])
    else $error("first bit is not the toggle echo");
  a_valid_single: assert property (word_valid_o |=> !word_valid_o)
    else $error("frame pulse longer than one cycle");
  a_valid_frame_end: assert property (word_valid_o |-> !spi_miso_oe_o
    && ($past(spi_miso_oe_o) || $past(spi_miso_oe_o, 2) || $past(spi_miso_oe_o, 3)))
    else $error("frame pulse without a frame end");
  a_fs_on_fault: assert property (overtemp_cond_i [*7] |-> failsafe_status_pin_o)
    else $error("fail-safe pin low during fault");
  a_fs_clear_cmd: assert property ($fell(failsafe_status_pin_o) && !direct_in_pin_i
    |-> spi_cs_n_i && !spi_miso_oe_o)
    else $error("fail-safe pin cleared outside a command");
  a_output_on_cmd: assert property (word_valid_o && last_word_o[6:4] == 3'h1
    |-> ##2 output_on_o == last_word_o[0])
    else $error("output-on bit not programmed");
endmodule
bind spi_status_readback_mux spi_status_readback_mux_assertions u_chk (
  .clock_i(clock_i), .rst_n_i(rst_n_i), .spi_cs_n_i(spi_cs_n_i),
  .overtemp_cond_i(overtemp_cond_i), .direct_in_pin_i(direct_in_pin_i),
  .spi_miso_o(spi_miso_o), .spi_miso_oe_o(spi_miso_oe_o),
  .failsafe_status_pin_o(failsafe_status_pin_o), .output_on_o(output_on_o),
  .word_valid_o(word_valid_o), .last_word_o(last_word_o)
);

// file: spi_status_readback_mux_bench.sv
// Self-checking bench for the SPI status readback block.
// Assumes the master model drives all three serial pins.
`timescale 1ns/1ps
module spi_status_readback_mux_bench;
  logic clock_i, rst_n_i, clk_en_i, spi_cs_n_i, spi_sclk_i, spi_mosi_i;
  logic undervoltage_latch_en_i, current_sense_disable_i, watchdog_expired_i;
  logic [3:0] oc_threshold_i, oc_timing_i, direct_input_control_reg_i;
  logic [3:0] switching_delay_reg_i;
  logic [1:0] watchdog_timeout_reg_i, voltage_protect_reg_i;
  logic direct_in_pin_i, failsafe_input_pin_i, wake_pin_i;
  logic spi_miso_o, spi_miso_oe_o, failsafe_status_pin_o, output_on_o, word_valid_o;
  logic [7:0] last_word_o, rsp;
  logic [5:0] cond;
  int n_errors = 0;
  int n_tests = 0;
  spi_status_readback_mux dut (.clock_i, .rst_n_i, .clk_en_i, .spi_cs_n_i, .spi_sclk_i,
    .spi_mosi_i, .overtemp_cond_i(cond[5]), .overcurrent_high_cond_i(cond[4]),
    .overcurrent_low_cond_i(cond[3]), .open_load_cond_i(cond[2]),
    .undervoltage_cond_i(cond[1]), .overvoltage_cond_i(cond[0]), .undervoltage_latch_en_i,
    .current_sense_disable_i, .oc_threshold_i, .oc_timing_i, .direct_input_control_reg_i,
    .switching_delay_reg_i, .watchdog_timeout_reg_i, .watchdog_expired_i,
    .voltage_protect_reg_i, .direct_in_pin_i, .failsafe_input_pin_i, .wake_pin_i,
    .spi_miso_o, .spi_miso_oe_o, .failsafe_status_pin_o, .output_on_o, .word_valid_o,
    .last_word_o);
  spi_master_model master (.clock_i, .miso_i(spi_miso_o), .miso_oe_i(spi_miso_oe_o),
    .cs_n_o(spi_cs_n_i), .sclk_o(spi_sclk_i), .mosi_o(spi_mosi_i));
  initial begin
    clock_i = 1'b0;
    forever #5 clock_i = ~clock_i;
  end
  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    n_tests++;
    if (seen !== exp) begin
      n_errors++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic summarize;
    $display("comparisons %0d mismatches %0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  task automatic xfer(input logic [7:0] cmd);
    master.frame(cmd, 8, rsp);
  endtask
  // Code in bits 6:4, payload in 3:0; echo equals the extra bit here
  function automatic logic [7:0] expect_word(input logic [3:0] s);
    logic [3:0] p;
    case (s)
      4'h1: p = {2'b00, current_sense_disable_i, 1'b1};
      4'h2: p = oc_threshold_i;
      4'h3: p = oc_timing_i;
      4'h4: p = direct_input_control_reg_i;
      4'h5: p = switching_delay_reg_i;
      4'hD: p = {1'b0, watchdog_expired_i, watchdog_timeout_reg_i};
      4'h6: p = {1'b0, direct_in_pin_i, failsafe_input_pin_i, wake_pin_i};
      4'hE: p = {2'b00, voltage_protect_reg_i};
      default: return {s[3], 7'h00};
    endcase
    return {s[3], s[2:0], p};
  endfunction
  task automatic t_reset;
    check("reset outputs", {5'h0, failsafe_status_pin_o, output_on_o, word_valid_o}, 8'h00);
    xfer(8'h87);
    check("first word", rsp & 8'h87, 8'h00);
    $display("test reset done");
  endtask
  task automatic t_faults;
    xfer(8'h00);
    check("null word", rsp, 8'h80);
    cond = 6'h1A;
    repeat (10) @(negedge clock_i);
    cond = 6'h25;
    repeat (10) @(negedge clock_i);
    check("fail-safe set", {7'h0, failsafe_status_pin_o}, 8'h01);
    xfer(8'h00);
    check("fault word", rsp, 8'h7F);
    cond = 6'h00;
    repeat (10) @(negedge clock_i);
    xfer(8'h11);
    check("latched flags", rsp & 8'hFE, 8'h30);
    check("after switch-on", {6'h0, failsafe_status_pin_o, output_on_o}, 8'h01);
    xfer(8'h00);
    xfer(8'h00);
    check("clean word", rsp, 8'h00);
    undervoltage_latch_en_i = 1'b0;
    cond = 6'h02;
    repeat (10) @(negedge clock_i);
    cond = 6'h00;
    repeat (10) @(negedge clock_i);
    xfer(8'h00);
    check("unlatched uv", rsp, 8'h01);
    direct_in_pin_i = 1'b1;
    repeat (10) @(negedge clock_i);
    check("fail-safe by input", {7'h0, failsafe_status_pin_o}, 8'h00);
    $display("test faults done");
  endtask
  task automatic t_modes;
    logic [3:0] sel [9] = '{4'h1, 4'h2, 4'h3, 4'h4, 4'h5, 4'hD, 4'h6, 4'hE, 4'h7};
    xfer({sel[0][3], 3'h0, sel[0]});
    for (int i = 1; i <= 9; i++) begin
      xfer(i < 9 ? {sel[i][3], 3'h0, sel[i]} : 8'h0F);
      check("readback word", rsp, expect_word(sel[i-1]));
    end
    $display("test modes done");
  endtask
  task automatic t_refused;
    xfer(8'h02);
    master.frame(8'h07, 5, rsp);
    check("last word after short frame", last_word_o, 8'h02);
    xfer(8'h07);
    check("select kept", rsp, {4'h2, oc_threshold_i});
    $display("test refused done");
  endtask
  initial begin
    rst_n_i = 1'b0;
    clk_en_i = 1'b1;
    cond = 6'h00;
    {undervoltage_latch_en_i, current_sense_disable_i, watchdog_expired_i} = 3'b111;
    {oc_threshold_i, oc_timing_i, direct_input_control_reg_i} = 12'hA59;
    {switching_delay_reg_i, watchdog_timeout_reg_i, voltage_protect_reg_i} = 8'hC9;
    {direct_in_pin_i, failsafe_input_pin_i, wake_pin_i} = 3'b001;
    repeat (12) @(negedge clock_i);
    rst_n_i = 1'b1;
    repeat (4) @(negedge clock_i);
    t_reset;
    t_faults;
    t_modes;
    t_refused;
    summarize;
  end
  initial begin
    #100000;
    n_errors++;
    $display("ERROR run time expected finish seen timeout");
    summarize;
  end
endmodule

// file: status_readback_map.svh
// Constants for the SPI status readback block: field positions, codes, widths.
// Assumes inclusion by the design modules by bare name.
// Function
// - Status bit 7 echoes previous watchdog toggle
// - Low seven bits chosen by stored select code
// - Code 000 returns fault flag word
// - Fault word order OT OCH OCL OL UV OV summary
// - Over-current high and low flags latch
// - Under-voltage flag latched or not by configuration
// - Summary fault bit cleared by its readout
// - Fail-safe status pin cleared by switch-on command
// - Code 001 returns sense disable and output-on
// - Code 010 returns over-current thresholds
// - Code 011 returns blanking, timeout, open-load enables
// - Code 100 returns direct-input control register
// - Code 101 extra 0 returns delay, failsafe state
// - Code 101 extra 1 returns watchdog, expired bit
// - Code 110 extra 0 returns input pin levels
// - Code 110 extra 1 returns voltage protect disables
// - Code 111 returns null data
// - Capture on select fall, shift out MSB first
// - Only whole-byte transfers update state, save summary and UV flag clears at select fall
`ifndef STATUS_READBACK_MAP_SVH
`define STATUS_READBACK_MAP_SVH
`define SEL_FAULT 3'h0
`define SEL_OUTCTL 3'h1
`define SEL_OCTHR 3'h2
`define SEL_OCTIME 3'h3
`define SEL_DIRECT_INPUT_CONTROL_REG 3'h4
`define SEL_DELAY_WD 3'h5
`define SEL_PINS_UOV 3'h6
`define SEL_NULL 3'h7
`define ADDR_STATUS_SELECT 3'h0
`define CMD_ADDR_MSB 6
`define CMD_ADDR_LSB 4
`define CMD_EXTRA_BIT 3
`define CMD_WD_BIT 7
`define CMD_ON_BIT 0
`define ADDR_OUTCTL_LOW 3'h1
`define BYTE_BITS 8
`define BIT_CNT_W 3
`define WD_EXPIRED_BIT 2
`define FSM_STATE_BIT 3
`endif

// file: status_readback_pkg.sv
// Types shared by the status readback design.
// Assumes the constant header is available on the include path.
package status_readback_pkg;
  typedef logic [6:0] low_bits_t;
  typedef logic [7:0] status_word_t;
  typedef enum logic [1:0] {
    LINK_IDLE = 2'b00,
    LINK_SHIFT = 2'b01,
    LINK_CLOSE = 2'b10
  } link_state_e;
endpackage

// file: status_word_mux.sv
// Combinational choice of the low seven status bits from the stored select code.
// Assumes all inputs are on clock_i and already synchronised.
`timescale 1ns/1ps
`include "status_readback_map.svh"
module status_word_mux (
  input wire logic [2:0] select_code_i,
  input wire logic extra_addr_i,
  input wire logic [6:0] fault_word_i,
  input wire logic current_sense_disable_i,
  input wire logic output_on_i,
  input wire logic [3:0] oc_threshold_i,
  input wire logic [3:0] oc_timing_i,
  input wire logic [3:0] direct_input_control_reg_i,
  input wire logic [3:0] switching_delay_reg_i,
  input wire logic [1:0] watchdog_timeout_reg_i,
  input wire logic watchdog_expired_i,
  input wire logic [2:0] input_pin_levels_i,
  input wire logic [1:0] voltage_protect_reg_i,
  output status_readback_pkg::low_bits_t low_bits_o
);
  import status_readback_pkg::*;
  always_comb begin
    low_bits_o = 7'h00;
    unique case (select_code_i)
      `SEL_FAULT: low_bits_o = fault_word_i;
      `SEL_OUTCTL: low_bits_o = {3'h1, 2'h0, current_sense_disable_i, output_on_i};
      `SEL_OCTHR: low_bits_o = {3'h2, oc_threshold_i};
      `SEL_OCTIME: low_bits_o = {3'h3, oc_timing_i};
      `SEL_DIRECT_INPUT_CONTROL_REG: low_bits_o = {3'h4, direct_input_control_reg_i};
      `SEL_DELAY_WD: begin
        if (extra_addr_i) begin
          low_bits_o = {3'h5, 1'b0, watchdog_expired_i, watchdog_timeout_reg_i};
        end else begin
          low_bits_o = {3'h5, switching_delay_reg_i};
        end
      end
      `SEL_PINS_UOV: begin
        if (extra_addr_i) begin
          low_bits_o = {3'h6, 2'h0, voltage_protect_reg_i};
        end else begin
          low_bits_o = {3'h6, 1'b0, input_pin_levels_i};
        end
      end
      `SEL_NULL: low_bits_o = 7'h00;
    endcase
  end
endmodule
